/* File: hdl/ue0_cfg.svh */
// Register map, field positions and reset values of the endpoint zero control block
`ifndef UE0_CFG_SVH
`define UE0_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define UE0_IDX_LOW 10'h102
`define UE0_IDX_HIGH 10'h103
`define UE0_IDX_CFG 10'h104
`define UE0_IDX_ISTAT 10'h105
`define UE0_IDX_IMASK 10'h106

// Low register, device layout
`define UE0_B_SETUP_END_CLEAR 7
`define UE0_B_RX_READY_CLEAR 6
`define UE0_B_SEND_STALL 5
`define UE0_B_SETUP_END_FLAG 4
`define UE0_B_LAST_DATA 3
`define UE0_B_STALLED 2
`define UE0_B_TX_READY 1
`define UE0_B_RX_READY 0

// High register; flush in both layouts, toggle bits in host layout only
`define UE0_B_TOGGLE_WE 2
`define UE0_B_TOGGLE 1
`define UE0_B_FLUSH 0

// Configuration register
`define UE0_B_HOST_MODE 0

// Interrupt status and mask layout
`define UE0_B_EV_EP0 0
`define UE0_B_EV_STALL 1
`define UE0_EV_WIDTH 2

`define UE0_RST_BYTE 8'h00
`define UE0_RST_EV 2'h0
`define UE0_RST_WORD 32'h0000_0000

`endif

/* File: hdl/ue0_device.sv */
// Endpoint zero control and status registers with APB access and link to the remote party
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "ue0_cfg.svh"
module ue0_device (
    input wire logic clk,                    // System clock, 200 MHz
    input wire logic rstn,                   // Asynchronous reset, active low
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB access phase
    input wire logic pwrite,                 // APB direction, high for write
    input wire ue0_pkg::ue0_addr_type paddr, // APB byte address
    input wire ue0_pkg::ue0_word_type pwdata, // APB write data
    output ue0_pkg::ue0_word_type prdata,    // APB read data
    output logic pready,                     // APB ready
    output logic pslverr,                    // APB error on unmapped address
    output logic irq,                        // Level interrupt
    ue0_link_if.dev link                     // Link to the remote party
);
    // ========================================================
    // Address decode
    function automatic logic reg_hit(input ue0_pkg::ue0_addr_type addr, input logic [9:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction : reg_hit

    logic host_mode;
    logic setup_end_flag;
    logic rx_packet_ready;
    logic send_stall;
    logic stalled;
    logic last_data_marker;
    logic toggle_write_enable;
    logic flush_busy;
    ue0_pkg::ue0_event_type int_status;
    ue0_pkg::ue0_event_type int_mask;
    ue0_pkg::ue0_event_type events;
    ue0_pkg::ue0_byte_type rd_byte;
    logic setup_cycle;
    logic access;
    logic wr;
    logic rd;
    logic wr_low;
    logic wr_high;
    logic wr_cfg;
    logic wr_mask;
    logic rd_status;
    logic mapped;
    logic early_end;

    assign setup_cycle = psel & ~penable & ~pready;
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign wr_low = wr & reg_hit(paddr, `UE0_IDX_LOW);
    assign wr_high = wr & reg_hit(paddr, `UE0_IDX_HIGH);
    assign wr_cfg = wr & reg_hit(paddr, `UE0_IDX_CFG);
    assign wr_mask = wr & reg_hit(paddr, `UE0_IDX_IMASK);
    assign rd_status = rd & reg_hit(paddr, `UE0_IDX_ISTAT);
    assign mapped = reg_hit(paddr, `UE0_IDX_LOW) | reg_hit(paddr, `UE0_IDX_HIGH)
        | reg_hit(paddr, `UE0_IDX_CFG) | reg_hit(paddr, `UE0_IDX_ISTAT)
        | reg_hit(paddr, `UE0_IDX_IMASK);
    // Transfer ended while the last data was not yet marked
    assign early_end = link.xfer_end & ~last_data_marker;

    // ========================================================
    // Read data; command bits show only a pending command
    always_comb begin
        rd_byte = `UE0_RST_BYTE;
        if (reg_hit(paddr, `UE0_IDX_LOW)) begin
            rd_byte[`UE0_B_SEND_STALL] = send_stall;
            rd_byte[`UE0_B_SETUP_END_FLAG] = setup_end_flag;
            rd_byte[`UE0_B_LAST_DATA] = last_data_marker;
            rd_byte[`UE0_B_STALLED] = stalled;
            rd_byte[`UE0_B_TX_READY] = link.tx_ready;
            rd_byte[`UE0_B_RX_READY] = rx_packet_ready;
        end else if (reg_hit(paddr, `UE0_IDX_HIGH)) begin
            rd_byte[`UE0_B_FLUSH] = flush_busy;
            if (host_mode) begin
                rd_byte[`UE0_B_TOGGLE_WE] = toggle_write_enable;
                rd_byte[`UE0_B_TOGGLE] = link.data_toggle;
            end
        end else if (reg_hit(paddr, `UE0_IDX_CFG)) begin
            rd_byte[`UE0_B_HOST_MODE] = host_mode;
        end else if (reg_hit(paddr, `UE0_IDX_ISTAT)) begin
            rd_byte[`UE0_EV_WIDTH-1:0] = int_status;
        end else if (reg_hit(paddr, `UE0_IDX_IMASK)) begin
            rd_byte[`UE0_EV_WIDTH-1:0] = int_mask;
        end
    end

    // ========================================================
    // APB slave: one setup cycle, then an access phase with no wait state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `UE0_RST_WORD;
        end else begin
            pready <= setup_cycle;
            if (setup_cycle) begin
                pslverr <= ~mapped;
                prdata <= {24'h00_0000, rd_byte};
            end else begin
                pslverr <= 1'b0;
                prdata <= `UE0_RST_WORD;
            end
        end
    end

    // ========================================================
    // Configuration
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            host_mode <= 1'b0;
        end else if (wr_cfg) begin
            host_mode <= pwdata[`UE0_B_HOST_MODE];
        end
    end

    // ========================================================
    // Receive side; a packet arriving with the clear keeps the flag set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_packet_ready <= 1'b0;
        end else if (link.rx_pkt) begin
            rx_packet_ready <= 1'b1;
        end else if ((wr_low && pwdata[`UE0_B_RX_READY_CLEAR]) || flush_busy) begin
            rx_packet_ready <= 1'b0;
        end
    end

    // ========================================================
    // Transmit side; a software set wins over a completion in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.tx_ready <= 1'b0;
        end else if (wr_low && pwdata[`UE0_B_TX_READY]) begin
            link.tx_ready <= 1'b1;
        end else if (link.tx_done || flush_busy) begin
            link.tx_ready <= 1'b0;
        end
    end

    // ========================================================
    // Last data marker, cleared when the transfer ends or is stalled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_data_marker <= 1'b0;
        end else if (wr_low && pwdata[`UE0_B_LAST_DATA]) begin
            last_data_marker <= 1'b1;
        end else if (link.xfer_end || link.stall_sent) begin
            last_data_marker <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.last_data <= 1'b0;
        end else begin
            link.last_data <= (wr_low && pwdata[`UE0_B_LAST_DATA])
                | (last_data_marker & ~link.xfer_end & ~link.stall_sent);
        end
    end

    // ========================================================
    // Setup end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            setup_end_flag <= 1'b0;
        end else if (early_end) begin
            setup_end_flag <= 1'b1;
        end else if (wr_low && pwdata[`UE0_B_SETUP_END_CLEAR]) begin
            setup_end_flag <= 1'b0;
        end
    end

    // ========================================================
    // Stall request and stalled status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            send_stall <= 1'b0;
        end else if (wr_low && pwdata[`UE0_B_SEND_STALL]) begin
            send_stall <= 1'b1;
        end else if (link.stall_sent) begin
            send_stall <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.stall_req <= 1'b0;
        end else begin
            link.stall_req <= (wr_low && pwdata[`UE0_B_SEND_STALL])
                | (send_stall & ~link.stall_sent);
        end
    end

    // Writing zero clears; writing one leaves it, so a read-modify-write is safe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stalled <= 1'b0;
        end else if (link.stall_sent) begin
            stalled <= 1'b1;
        end else if (wr_low && !pwdata[`UE0_B_STALLED]) begin
            stalled <= 1'b0;
        end
    end

    // ========================================================
    // Data toggle, host layout only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            toggle_write_enable <= 1'b0;
        end else if (wr_high && host_mode && pwdata[`UE0_B_TOGGLE_WE]) begin
            toggle_write_enable <= 1'b1;
        end else if (wr_high && host_mode && toggle_write_enable) begin
            toggle_write_enable <= 1'b0;
        end
    end

    // Each cycle with a completed packet (rx_pkt or tx_done, or both) flips the toggle once unless software overrides it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.data_toggle <= 1'b0;
        end else if (wr_high && host_mode && toggle_write_enable) begin
            link.data_toggle <= pwdata[`UE0_B_TOGGLE];
        end else if (link.tx_done || link.rx_pkt) begin
            link.data_toggle <= ~link.data_toggle;
        end
    end

    // ========================================================
    // Flush: one cycle busy, which resets the FIFO pointer and ready bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flush_busy <= 1'b0;
            link.fifo_flush <= 1'b0;
        end else begin
            flush_busy <= wr_high & pwdata[`UE0_B_FLUSH];
            link.fifo_flush <= wr_high & pwdata[`UE0_B_FLUSH];
        end
    end

    // ========================================================
    // Interrupts: sticky status, cleared by reading it; new events win
    always_comb begin
        events = `UE0_RST_EV;
        events[`UE0_B_EV_EP0] = link.rx_pkt | link.tx_done | early_end;
        events[`UE0_B_EV_STALL] = link.stall_sent;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_status <= `UE0_RST_EV;
        end else if (rd_status) begin
            int_status <= events;
        end else begin
            int_status <= int_status | events;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_mask <= `UE0_RST_EV;
        end else if (wr_mask) begin
            int_mask <= pwdata[`UE0_EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end
endmodule : ue0_device
`default_nettype wire

/* File: hdl/ue0_far.sv */
// Remote USB party end of the endpoint zero link
`timescale 1ns/100ps
`default_nettype none
`include "ue0_cfg.svh"
module ue0_far (
    input wire logic clk,            // System clock
    input wire logic rstn,           // Asynchronous reset, active low
    ue0_link_if.far link,            // Link to the controller
    input wire logic user_send_pkt,  // Deliver one data packet into the receive FIFO
    input wire logic user_take_pkt,  // Issue an IN token for one packet
    input wire logic user_end_xfer,  // End the current control transfer
    output logic in_data,            // Pulse: IN packet collected
    output logic in_nak,             // Pulse: IN token found nothing ready
    output logic stall_seen,         // Pulse: STALL handshake taken
    output logic toggle_seen         // Toggle the controller shows
);
    // ========================================================
    // Packet traffic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.rx_pkt <= 1'b0;
            link.xfer_end <= 1'b0;
        end else begin
            link.rx_pkt <= user_send_pkt;
            link.xfer_end <= user_end_xfer;
        end
    end

    // A pending stall aborts the data stage, so no packet is collected then
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.tx_done <= 1'b0;
            in_data <= 1'b0;
            in_nak <= 1'b0;
        end else begin
            link.tx_done <= user_take_pkt & link.tx_ready & ~link.tx_done & ~link.stall_req;
            in_data <= user_take_pkt & link.tx_ready & ~link.tx_done & ~link.stall_req;
            in_nak <= user_take_pkt & ~(link.tx_ready & ~link.tx_done);
        end
    end

    // ========================================================
    // Stall handshake; the guard keeps one request to one pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.stall_sent <= 1'b0;
            stall_seen <= 1'b0;
            toggle_seen <= 1'b0;
        end else begin
            link.stall_sent <= link.stall_req & ~link.stall_sent;
            stall_seen <= link.stall_req & ~link.stall_sent;
            toggle_seen <= link.data_toggle;
        end
    end
endmodule : ue0_far
`default_nettype wire

/* File: hdl/ue0_link_if.sv */
// Link between the endpoint zero controller and the remote USB party
`timescale 1ns/100ps
`default_nettype none
interface ue0_link_if;
    // Controller to remote party
    logic tx_ready;
    logic stall_req;
    logic data_toggle;
    logic last_data;
    logic fifo_flush;
    // Remote party to controller, one-cycle pulses
    logic rx_pkt;
    logic tx_done;
    logic stall_sent;
    logic xfer_end;

    modport dev (
        output tx_ready, stall_req, data_toggle, last_data, fifo_flush,
        input rx_pkt, tx_done, stall_sent, xfer_end
    );
    modport far (
        input tx_ready, stall_req, data_toggle, last_data, fifo_flush,
        output rx_pkt, tx_done, stall_sent, xfer_end
    );
endinterface : ue0_link_if
`default_nettype wire

/* File: hdl/ue0_pkg.sv */
// Shared types of the endpoint zero control block
`default_nettype none
package ue0_pkg;
    typedef logic [7:0] ue0_byte_type;
    typedef logic [31:0] ue0_word_type;
    typedef logic [11:0] ue0_addr_type;
    typedef logic [1:0] ue0_event_type;
endpackage : ue0_pkg
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench driving both ends of the endpoint zero link
`timescale 1ns/100ps
`default_nettype none
`include "ue0_cfg.svh"
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pready, pslverr, irq, in_data, in_nak, stall_seen, toggle_seen, rerr;
    logic [2:0] ev = 3'b000;
    ue0_pkg::ue0_addr_type paddr = 12'h000;
    ue0_pkg::ue0_word_type pwdata = 32'h0000_0000;
    ue0_pkg::ue0_word_type prdata, rdata;
    int err_total = 0;
    int check_count = 0;
    int in_cnt = 0;
    int stall_cnt = 0;
    int nak_cnt = 0;
    ue0_link_if link();
    ue0_device ue0_device_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    ue0_far ue0_far_i (.clk(clk), .rstn(rstn), .link(link), .user_send_pkt(ev[0]),
        .user_take_pkt(ev[1]), .user_end_xfer(ev[2]), .in_data(in_data), .in_nak(in_nak),
        .stall_seen(stall_seen), .toggle_seen(toggle_seen));
    ue0_link_asserts ue0_link_asserts_i (.clk(clk), .rstn(rstn), .tx_ready(link.tx_ready),
        .stall_req(link.stall_req), .data_toggle(link.data_toggle), .last_data(link.last_data),
        .fifo_flush(link.fifo_flush), .rx_pkt(link.rx_pkt), .tx_done(link.tx_done),
        .stall_sent(link.stall_sent), .xfer_end(link.xfer_end));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        in_cnt += int'(in_data === 1'b1);
        stall_cnt += int'(stall_seen === 1'b1);
        nak_cnt += int'(in_nak === 1'b1);
    end
    // ==========================================
    // Tasks
    task automatic chk(input string name, input ue0_pkg::ue0_byte_type exp,
        input ue0_pkg::ue0_byte_type got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One APB transfer; waits for pready, and only the watchdog ends a dead wait
    task automatic apb(input logic w, input logic [9:0] idx, input ue0_pkg::ue0_byte_type wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [9:0] idx, input ue0_pkg::ue0_byte_type exp, input string s);
        apb(1'b0, idx, 8'h00);
        chk(s, exp, rdata[7:0]);
    endtask : rd
    // Pulse one far-end request: 0 deliver, 1 collect, 2 end transfer
    task automatic far_ev(input int k);
        ev <= 3'(1 << k);
        @(posedge clk);
        ev <= 3'b000;
        repeat (4) @(posedge clk);
    endtask : far_ev
    task automatic done(input string s);
        $display("Test %s finished, mismatches so far %0d", s, err_total);
    endtask : done
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // ==========================================
    // Watchdog, far above the roughly 170 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end
    // ==========================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`UE0_IDX_LOW, 8'h00, "low");
        rd(`UE0_IDX_HIGH, 8'h00, "high");
        rd(`UE0_IDX_ISTAT, 8'h00, "istat");
        rd(`UE0_IDX_IMASK, 8'h00, "imask");
        done("reset");
        far_ev(0);
        chk("irq masked", 8'h00, 8'(irq));
        apb(1'b1, `UE0_IDX_LOW, 8'h00);
        rd(`UE0_IDX_LOW, 8'h01, "rx ready");
        apb(1'b1, `UE0_IDX_IMASK, 8'h03);
        // The interrupt output is a flop behind the mask, so let its edge pass
        @(posedge clk);
        chk("irq", 8'h01, 8'(irq));
        rd(`UE0_IDX_ISTAT, 8'h01, "istat rx");
        repeat (2) @(posedge clk);
        chk("irq cleared", 8'h00, 8'(irq));
        apb(1'b1, `UE0_IDX_LOW, 8'h40);
        rd(`UE0_IDX_LOW, 8'h00, "rx clear");
        done("receive");
        apb(1'b1, `UE0_IDX_LOW, 8'h0a);
        rd(`UE0_IDX_LOW, 8'h0a, "tx set");
        far_ev(1);
        chk("in data", 8'h01, 8'(in_cnt));
        rd(`UE0_IDX_LOW, 8'h08, "tx sent");
        rd(`UE0_IDX_ISTAT, 8'h01, "istat tx");
        far_ev(2);
        rd(`UE0_IDX_LOW, 8'h00, "end after last");
        // A token with nothing ready is refused and collects no packet
        far_ev(1);
        chk("in nak", 8'h01, 8'(nak_cnt));
        chk("no extra data", 8'h01, 8'(in_cnt));
        done("transmit");
        far_ev(2);
        rd(`UE0_IDX_LOW, 8'h10, "setup end");
        rd(`UE0_IDX_ISTAT, 8'h01, "istat end");
        apb(1'b1, `UE0_IDX_LOW, 8'h00);
        rd(`UE0_IDX_LOW, 8'h10, "zero write");
        apb(1'b1, `UE0_IDX_LOW, 8'h80);
        rd(`UE0_IDX_LOW, 8'h00, "end clear");
        done("setup end");
        apb(1'b1, `UE0_IDX_LOW, 8'h20);
        repeat (3) @(posedge clk);
        chk("stall seen", 8'h01, 8'(stall_cnt));
        rd(`UE0_IDX_LOW, 8'h04, "stalled");
        rd(`UE0_IDX_ISTAT, 8'h02, "istat stall");
        apb(1'b1, `UE0_IDX_LOW, 8'h00);
        rd(`UE0_IDX_LOW, 8'h00, "stall clear");
        done("stall");
        // Flush only with a packet pending, otherwise the FIFO pointer would be corrupted
        apb(1'b1, `UE0_IDX_LOW, 8'h02);
        apb(1'b1, `UE0_IDX_HIGH, 8'h01);
        rd(`UE0_IDX_HIGH, 8'h00, "flush self");
        rd(`UE0_IDX_LOW, 8'h00, "flush tx");
        far_ev(0);
        apb(1'b1, `UE0_IDX_HIGH, 8'h01);
        rd(`UE0_IDX_LOW, 8'h00, "flush rx");
        done("flush");
        // Toggle has flipped three times, so it stands at one
        apb(1'b1, `UE0_IDX_CFG, 8'h01);
        apb(1'b1, `UE0_IDX_HIGH, 8'h00);
        rd(`UE0_IDX_HIGH, 8'h02, "toggle locked");
        apb(1'b1, `UE0_IDX_HIGH, 8'h04);
        rd(`UE0_IDX_HIGH, 8'h06, "toggle enable");
        apb(1'b1, `UE0_IDX_HIGH, 8'h00);
        rd(`UE0_IDX_HIGH, 8'h00, "toggle write");
        repeat (2) @(posedge clk);
        chk("toggle seen", 8'h00, 8'(toggle_seen));
        apb(1'b1, `UE0_IDX_CFG, 8'h00);
        done("toggle");
        apb(1'b0, 10'h107, 8'h00);
        chk("unmapped err", 8'h01, 8'(rerr));
        chk("unmapped data", 8'h00, rdata[7:0]);
        done("unmapped");
        final_report();
    end
endmodule : testbench
`default_nettype wire

/* File: verif/ue0_link_asserts.sv */
// Concurrent checks on the endpoint zero link between the two ends
`timescale 1ns/100ps
`default_nettype none
module ue0_link_asserts (
    input wire logic clk,         // System clock
    input wire logic rstn,        // Asynchronous reset, active low
    input wire logic tx_ready,    // Transmit packet ready
    input wire logic stall_req,   // Stall requested
    input wire logic data_toggle, // Endpoint zero toggle
    input wire logic last_data,   // Last-data marker
    input wire logic fifo_flush,  // FIFO pointer reset pulse
    input wire logic rx_pkt,      // Packet delivered pulse
    input wire logic tx_done,     // Packet collected pulse
    input wire logic stall_sent,  // Stall handshake pulse
    input wire logic xfer_end     // Transfer end pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // Stall handshake
    sequence stall_hs;
        stall_req ##1 stall_sent ##1 !stall_req;
    endsequence
    a_stall_handshake: assert property ($rose(stall_req) |-> stall_hs)
        else $error("stall request not answered and dropped in time");
    a_stall_holds: assert property (stall_req && !stall_sent |=> stall_req)
        else $error("stall request dropped before the handshake");
    a_stall_sent_cause: assert property (stall_sent |-> $past(stall_req))
        else $error("stall handshake without a request");
    // ==========================================
    // Packet and transfer events
    a_tx_done_ready: assert property (tx_done |-> tx_ready ##1 !tx_ready)
        else $error("transmit ready not cleared after collection");
    a_toggle_flips: assert property ((rx_pkt ^ tx_done) |=> data_toggle != $past(data_toggle))
        else $error("toggle did not flip on a packet");
    a_last_data_end: assert property ((xfer_end || stall_sent) |=> !last_data)
        else $error("last-data marker survived the transfer end");
    // Flush is one cycle and must take the transmit packet with it
    a_flush_pulse: assert property (fifo_flush |=> !fifo_flush)
        else $error("flush longer than one cycle");
    a_flush_clears: assert property (fifo_flush |-> ##[0:1] !tx_ready)
        else $error("flush left transmit ready set");
endmodule : ue0_link_asserts
`default_nettype wire
